// *** common/csb_pkg.sv ***
`default_nettype none
package csb_pkg;

	// ==========================================================
	// widths
	localparam int CSB_PC_W    = 16;
	localparam int CSB_OFS_W   = 7;
	localparam int CSB_CYC_W   = 2;

	// ==========================================================
	// status flag positions (plain defaults of the core)
	localparam logic [2:0] CSB_FLAG_C_POS = 3'h0;
	localparam logic [2:0] CSB_FLAG_Z_POS = 3'h1;

	// ==========================================================
	// program counter steps in words
	localparam logic [CSB_PC_W-1:0] CSB_PC_STEP_SEQ  = 16'h0001;
	localparam logic [CSB_PC_W-1:0] CSB_PC_STEP_SKP1 = 16'h0002;
	localparam logic [CSB_PC_W-1:0] CSB_PC_STEP_SKP2 = 16'h0003;

	// ==========================================================
	// cycle counts
	localparam logic [CSB_CYC_W-1:0] CSB_CYC_NOT_TAKEN = 2'h1;
	localparam logic [CSB_CYC_W-1:0] CSB_CYC_BRANCH    = 2'h2;
	localparam logic [CSB_CYC_W-1:0] CSB_CYC_SKIP1     = 2'h2;
	localparam logic [CSB_CYC_W-1:0] CSB_CYC_SKIP2     = 2'h3;

	// ==========================================================
	// reset values
	localparam logic [CSB_PC_W-1:0]  CSB_PC_RST  = 16'h0000;
	localparam logic [CSB_CYC_W-1:0] CSB_CYC_RST = 2'h0;

	typedef enum logic [3:0] {
		CSB_OP_SKIP_IO_BIT_CLEAR        = 4'h0,
		CSB_OP_SKIP_IO_BIT_SET          = 4'h1,
		CSB_OP_BRANCH_FLAG_SET_GENERIC  = 4'h2,
		CSB_OP_BRANCH_FLAG_CLEAR_GENERIC= 4'h3,
		CSB_OP_BRANCH_ZERO_SET          = 4'h4,
		CSB_OP_BRANCH_ZERO_CLEAR        = 4'h5,
		CSB_OP_BRANCH_CARRY_SET         = 4'h6,
		CSB_OP_BRANCH_CARRY_CLEAR       = 4'h7,
		CSB_OP_BRANCH_UNSIGNED_GE       = 4'h8
	} csb_op_t;

	typedef struct packed {
		csb_op_t                op;
		logic [2:0]             bit_sel;
		logic [CSB_OFS_W-1:0]   offset;
		logic [7:0]             io_data;
		logic                   next_two_word;
		logic [CSB_PC_W-1:0]    pc;
	} csb_req_t;

	typedef struct packed {
		logic                   taken;
		logic [CSB_CYC_W-1:0]   cycles;
		logic [CSB_PC_W-1:0]    next_pc;
	} csb_resp_t;

	typedef enum logic [0:0] {
		CSB_ST_IDLE  = 1'h0,
		CSB_ST_STALL = 1'h1
	} csb_state_t;

endpackage : csb_pkg
`default_nettype wire

// *** logic/csb_cond_eval.sv ***
`timescale 1ns/1ps
`default_nettype none

module csb_cond_eval (
	input  wire csb_pkg::csb_op_t op,
	input  wire logic [2:0]       bit_sel,
	input  wire logic [7:0]       flags,
	input  wire logic [7:0]       io_data,
	output logic                  is_skip,
	output logic                  taken
);

	// ==========================================================
	// condition select
	always_comb
	begin
		is_skip = 1'h0;
		taken   = 1'h0;
		case (op)
			csb_pkg::CSB_OP_SKIP_IO_BIT_CLEAR:
			begin
				is_skip = 1'h1;
				taken   = ~io_data[bit_sel];
			end
			csb_pkg::CSB_OP_SKIP_IO_BIT_SET:
			begin
				is_skip = 1'h1;
				taken   = io_data[bit_sel];
			end
			csb_pkg::CSB_OP_BRANCH_FLAG_SET_GENERIC:
				taken = flags[bit_sel];
			csb_pkg::CSB_OP_BRANCH_FLAG_CLEAR_GENERIC:
				taken = ~flags[bit_sel];
			csb_pkg::CSB_OP_BRANCH_ZERO_SET:
				taken = flags[csb_pkg::CSB_FLAG_Z_POS];
			csb_pkg::CSB_OP_BRANCH_ZERO_CLEAR:
				taken = ~flags[csb_pkg::CSB_FLAG_Z_POS];
			csb_pkg::CSB_OP_BRANCH_CARRY_SET:
				taken = flags[csb_pkg::CSB_FLAG_C_POS];
			csb_pkg::CSB_OP_BRANCH_CARRY_CLEAR,
			csb_pkg::CSB_OP_BRANCH_UNSIGNED_GE:
				taken = ~flags[csb_pkg::CSB_FLAG_C_POS];
			default:
				taken = 1'h0;
		endcase
	end

endmodule : csb_cond_eval

`default_nettype wire

// *** logic/csb_unit.sv ***
// Summary of operation
// - io bit clear: skip next instruction
// - io bit set: skip next instruction
// - selected flag set: branch pc+k+1
// - selected flag clear: branch pc+k+1
// - zero set/clear branches to pc+k+1
// - carry set branches to pc+k+1
// - carry clear or same-or-higher branches
`timescale 1ns/1ps
`default_nettype none

module csb_unit (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                req_valid,
	input  wire csb_pkg::csb_req_t   req,
	input  wire logic [7:0]          status_flags_register,
	output logic                     req_ready,
	output logic                     resp_valid,
	output csb_pkg::csb_resp_t       resp
);

	// ==========================================================
	// condition
	logic                               is_skip;
	logic                               cond_taken;
	logic                               accept;
	logic [csb_pkg::CSB_PC_W-1:0]       ofs_ext;
	logic [csb_pkg::CSB_PC_W-1:0]       seq_pc;
	logic [csb_pkg::CSB_PC_W-1:0]       skip_pc;
	logic [csb_pkg::CSB_PC_W-1:0]       branch_pc;
	logic [csb_pkg::CSB_CYC_W-1:0]      skip_cyc;
	logic [csb_pkg::CSB_PC_W-1:0]       pc_d;
	logic [csb_pkg::CSB_CYC_W-1:0]      cyc_d;
	logic                               stall_start;
	logic                               stall_end;
	csb_pkg::csb_state_t                state_d;
	csb_pkg::csb_state_t                state_q;
	logic [csb_pkg::CSB_CYC_W-1:0]      stall_q;
	logic                               ready_q;
	logic                               valid_q;
	csb_pkg::csb_resp_t                 resp_q;

	csb_cond_eval csb_cond_eval_i (
		.op      (req.op),
		.bit_sel (req.bit_sel),
		.flags   (status_flags_register),
		.io_data (req.io_data),
		.is_skip (is_skip),
		.taken   (cond_taken)
	);

	assign accept = req_valid & ready_q;

	// ==========================================================
	// offset sign extension
	// low bits copy the offset, every bit above repeats its sign bit
	generate
		for (genvar gi = 0; gi < csb_pkg::CSB_PC_W; gi++)
		begin : g_ofs_ext
			if (gi < csb_pkg::CSB_OFS_W)
			begin : g_low
				assign ofs_ext[gi] = req.offset[gi];
			end
			else
			begin : g_sign
				assign ofs_ext[gi] = req.offset[csb_pkg::CSB_OFS_W-1];
			end
		end
	endgenerate

	// ==========================================================
	// candidate targets
	// every sum wraps in the word space, as the pc itself does;
	// a branch near either end of memory lands on the other end
	assign seq_pc    = req.pc + csb_pkg::CSB_PC_STEP_SEQ;
	assign skip_pc   = req.next_two_word ? req.pc + csb_pkg::CSB_PC_STEP_SKP2
		: req.pc + csb_pkg::CSB_PC_STEP_SKP1;
	assign skip_cyc  = req.next_two_word ? csb_pkg::CSB_CYC_SKIP2
		: csb_pkg::CSB_CYC_SKIP1;
	assign branch_pc = req.pc + ofs_ext + csb_pkg::CSB_PC_STEP_SEQ;

	// ==========================================================
	// next pc and cycle cost
	always_comb
	begin
		pc_d  = seq_pc;
		cyc_d = csb_pkg::CSB_CYC_NOT_TAKEN;
		if (cond_taken && is_skip)
		begin
			pc_d  = skip_pc;
			cyc_d = skip_cyc;
		end
		else if (cond_taken)
		begin
			pc_d  = branch_pc;
			cyc_d = csb_pkg::CSB_CYC_BRANCH;
		end
	end

	// ==========================================================
	// stall control
	// only a taken branch or skip costs extra cycles; a fall-through
	// keeps the unit open so requests may follow every cycle
	assign stall_start = accept && (cyc_d != csb_pkg::CSB_CYC_NOT_TAKEN);
	assign stall_end   = (state_q == csb_pkg::CSB_ST_STALL)
		&& (stall_q == csb_pkg::CSB_CYC_NOT_TAKEN);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			csb_pkg::CSB_ST_IDLE:
			begin
				if (stall_start)
				begin
					state_d = csb_pkg::CSB_ST_STALL;
				end
			end
			csb_pkg::CSB_ST_STALL:
			begin
				if (stall_end)
				begin
					state_d = csb_pkg::CSB_ST_IDLE;
				end
			end
			default:
			begin
				state_d = csb_pkg::CSB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_q <= csb_pkg::CSB_ST_IDLE;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// remaining stall cycles
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			stall_q <= csb_pkg::CSB_CYC_RST;
		end
		else if (stall_start)
		begin
			stall_q <= cyc_d - csb_pkg::CSB_CYC_NOT_TAKEN;
		end
		else if (state_q == csb_pkg::CSB_ST_STALL)
		begin
			stall_q <= stall_q - csb_pkg::CSB_CYC_NOT_TAKEN;
		end
	end

	// ==========================================================
	// ready
	// low from the taking edge until the stall count runs out; a request
	// offered meanwhile is simply not taken and leaves no trace
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ready_q <= 1'h0;
		end
		else if (stall_start)
		begin
			ready_q <= 1'h0;
		end
		else if ((state_q == csb_pkg::CSB_ST_IDLE) || stall_end)
		begin
			ready_q <= 1'h1;
		end
	end

	// ==========================================================
	// answer strobe, one pulse per taken request
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			valid_q <= 1'h0;
		end
		else
		begin
			valid_q <= accept;
		end
	end

	// ==========================================================
	// answer fields
	// there is no flag output, so the flags cannot change here;
	// fields hold until the next taken request for a slow reader
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			resp_q <= '{taken: 1'h0, cycles: csb_pkg::CSB_CYC_RST,
				next_pc: csb_pkg::CSB_PC_RST};
		end
		else if (accept)
		begin
			resp_q <= '{taken: cond_taken, cycles: cyc_d, next_pc: pc_d};
		end
	end

	// ==========================================================
	// outputs, each straight from its register
	assign req_ready  = ready_q;
	assign resp_valid = valid_q;
	assign resp       = resp_q;

endmodule : csb_unit

`default_nettype wire

// *** tb/csb_tb_pkg.sv ***
`default_nettype none
package csb_tb_pkg;
	// ========
	// expected answer to one taken request
	function automatic csb_pkg::csb_resp_t exp_of(csb_pkg::csb_req_t r, logic [7:0] f);
		logic s;
		csb_pkg::csb_resp_t e;
		s = r.op < 4'h2 ? r.io_data[r.bit_sel] : r.op < 4'h4 ? f[r.bit_sel]
			: f[r.op < 4'h6 ? csb_pkg::CSB_FLAG_Z_POS : csb_pkg::CSB_FLAG_C_POS];
		e.taken = s ^ !(r.op inside {4'h1, 4'h2, 4'h4, 4'h6});
		e.cycles = !e.taken ? 2'h1 : 2'h2 + (r.op < 4'h2 ? r.next_two_word : 1'h0);
		e.next_pc = !e.taken ? r.pc + 16'h1 : r.op < 4'h2 ? r.pc + 16'h2 + r.next_two_word
			: r.pc + {{9{r.offset[6]}}, r.offset} + 16'h1;
		return e;
	endfunction : exp_of
endpackage : csb_tb_pkg
`default_nettype wire

// *** tb/csb_unit_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module csb_unit_monitor (
	input wire logic               core_clk,
	input wire logic               reset,
	input wire logic               req_valid,
	input wire csb_pkg::csb_req_t  req,
	input wire logic [7:0]         status_flags_register,
	input wire logic               req_ready,
	input wire logic               resp_valid,
	input wire csb_pkg::csb_resp_t resp
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ========
	// expectation latched at the taking edge
	logic               acc;
	logic [3:0]         op_q;
	csb_pkg::csb_resp_t e_q;
	assign acc = req_valid && req_ready;
	always_ff @(posedge core_clk)
		if (acc)
		begin
			op_q <= req.op;
			e_q <= csb_tb_pkg::exp_of(req, status_flags_register);
		end
	property p_op(o);
		resp_valid && op_q == o |-> resp == e_q;
	endproperty
	a_skip_clr: assert property (p_op(4'h0)) else $error("bad resp");
	a_skip_set: assert property (p_op(4'h1)) else $error("bad resp");
	a_flag_set: assert property (p_op(4'h2)) else $error("bad resp");
	a_flag_clr: assert property (p_op(4'h3)) else $error("bad resp");
	a_zero_set: assert property (p_op(4'h4)) else $error("bad resp");
	a_zero_clr: assert property (p_op(4'h5)) else $error("bad resp");
	a_carry_set: assert property (p_op(4'h6)) else $error("bad resp");
	a_carry_clr: assert property (p_op(4'h7)) else $error("bad resp");
	a_unsigned_ge: assert property (p_op(4'h8)) else $error("bad resp");
	a_resp_latency: assert property (acc |=> resp_valid) else $error("no resp");
	a_resp_cause: assert property (resp_valid |-> $past(acc)) else $error("stray resp");
	a_ready_skip: assert property (resp_valid && resp.cycles == 2'h3
		|-> !req_ready ##1 !req_ready ##1 req_ready) else $error("ready gap");
	a_ready_branch: assert property (resp_valid && resp.cycles == 2'h2
		|-> !req_ready ##1 req_ready) else $error("ready gap");
	c_skip_two: cover property (resp_valid && resp.cycles == 2'h3);
	c_back_to_back: cover property (acc ##1 acc);
	c_branch_taken: cover property (resp_valid && resp.taken && op_q > 4'h1);
endmodule : csb_unit_monitor
bind csb_unit csb_unit_monitor csb_unit_monitor_i (.core_clk(core_clk), .reset(reset),
	.req_valid(req_valid), .req(req), .status_flags_register(status_flags_register),
	.req_ready(req_ready), .resp_valid(resp_valid), .resp(resp));
`default_nettype wire

// *** tb/csb_unit_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module csb_unit_tb_top;
	logic               core_clk;
	logic               reset;
	logic               req_valid;
	csb_pkg::csb_req_t  req;
	logic [7:0]         flags;
	logic               req_ready;
	logic               resp_valid;
	csb_pkg::csb_resp_t resp;
	csb_pkg::csb_resp_t exp_q[$];
	logic [31:0]        x;
	int                 n_mismatch;
	int                 samples_checked;
	int                 k;
	csb_unit csb_unit_i (.core_clk(core_clk), .reset(reset), .req_valid(req_valid), .req(req),
		.status_flags_register(flags), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp(resp));
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic give_verdict();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic check_resp(input csb_pkg::csb_resp_t got);
		csb_pkg::csb_resp_t want;
		samples_checked++;
		if (exp_q.size() == 0)
		begin
			n_mismatch++;
			$display("mismatch %0t answer without request %h", $time, got);
		end
		else
		begin
			want = exp_q.pop_front();
			if (got !== want)
			begin
				n_mismatch++;
				$display("mismatch %0t resp %h expected %h", $time, got, want);
			end
		end
	endtask : check_resp
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ========
	// watcher: oldest note against each answer
	always @(posedge core_clk)
	begin
		#1;
		if (resp_valid === 1'h1)
		begin
			check_resp(resp);
		end
	end
	// ========
	// driver: valid held while refused, so early takes show as extra answers
	initial
	begin
		reset = 1'h1;
		req_valid = 1'h0;
		req = '0;
		flags = 8'h00;
		x = 32'h15C6;
		repeat (20) @(posedge core_clk);
		#2;
		reset = 1'h0;
		for (int i = 0; i < 600; i++)
		begin
			x = xs(x);
			req.op = csb_pkg::csb_op_t'(4'(x[7:0] % 8'h9));
			{req.bit_sel, req.offset, req.next_two_word} = x[18:8];
			req_valid = x[31:29] != 3'h0;
			x = xs(x);
			{req.pc, req.io_data, flags} = x;
			k = 0;
			while (req_valid && (req_ready !== 1'h1) && (k < 8))
			begin
				@(posedge core_clk);
				#2;
				k++;
			end
			if (req_valid && (req_ready !== 1'h1))
			begin
				n_mismatch++;
				$display("mismatch %0t ready timeout", $time);
				break;
			end
			@(posedge core_clk);
			if (req_valid)
				exp_q.push_back(csb_tb_pkg::exp_of(req, flags));
			#2;
		end
		req_valid = 1'h0;
		repeat (4) @(posedge core_clk);
		if (exp_q.size() != 0)
		begin
			n_mismatch += exp_q.size();
			$display("mismatch %0t %0d answers missing", $time, exp_q.size());
		end
		give_verdict();
	end
endmodule : csb_unit_tb_top
`default_nettype wire
